// *** hdl/fcs_consts.svh ***
// Constants for the frequency counter sequencer
// Contract
// - Second counter input path is enabled only while the carrier is detected.
// - A reset pulse clears the first counter at each cycle start.
// - While gate is high the first counter counts each passed mixing pulse.
// - When gate falls the first counter stops and holds its value.
// - A load pulse presets the second counter with the first counter value.
// - During the next gate window the second counter counts up from preset.
// - After that window the second counter stops and keeps its total.
// - A latch pulse copies the second counter total into the display latch.
// - One gate drives both counters; the sequence repeats forever.
// - Cycles overlap by half a cycle, first counter measuring the next cycle.
// - Reference clock divides through six decade stages down to 10 Hz.
// - 10 Hz toggles a flip-flop making 5 Hz; its high half is the gate.
// - Reset, load, latch pulses decoded in nine fixed slots outside the gate.
// - Two resets: active low clears first counter; active high second_rst is generated but clears nothing.
// - Latch every 0.2 s; display keeps the last captured count between.
// - While freeze is on, latch pulses are blocked from the latch.
// - After power-up with freeze on, latches still pass for a few cycles.
// - Second counter receives pulses only in display mode, not counter mode.
`ifndef FCS_CONSTS_SVH
`define FCS_CONSTS_SVH
// ==========================================
// Timebase
`define FCS_REF_HZ 100000000
`define FCS_TICK_HZ 10
`define FCS_DECADES 6
`define FCS_DECADE_LAST 4'h9
`define FCS_SLOTS 9
`define FCS_SLOT_RESET 4'h7
`define FCS_SLOT_LOAD 4'h4
`define FCS_SLOT_LATCH 4'h2
`define FCS_POWERUP_CYCLES 4'h4
`define FCS_CNT_W 24
`endif

// *** hdl/fcs_pkg.sv ***
// Types for the frequency counter sequencer
`include "fcs_consts.svh"
package fcs_pkg;
  typedef struct packed {
    logic [2:0] mix_sync;
    logic [2:0] tune_sync;
    logic mix_prev;
    logic tune_prev;
  } fcs_sync_s;
  typedef struct packed {
    fcs_sync_s sync;
    logic [19:0] pre;
    logic [6*4-1:0] dec;
    logic gate;
    logic [3:0] slot;
    logic [3:0] slot_div;
    logic first_rst_n;
    logic second_rst;
    logic load;
    logic latch;
    logic [3:0] boot;
    logic [`FCS_CNT_W-1:0] first_cnt;
    logic [`FCS_CNT_W-1:0] second_cnt;
    logic [`FCS_CNT_W-1:0] shown;
    logic shown_valid;
  } fcs_state_s;
endpackage : fcs_pkg

// *** hdl/fcs_core.sv ***
// Frequency counter sequencer core
`include "fcs_consts.svh"
module fcs_core
  import fcs_pkg::*;
#(
  parameter int PRESCALE = 10,
  parameter int SLOT_TICKS = 1,
  parameter int DECADES = `FCS_DECADES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Oscillator pulse inputs
  input wire logic mixing_osc_input,
  input wire logic tuning_osc_input,
  // Controls
  input wire logic beat_osc_input,
  input wire logic display_mode,
  input wire logic display_freeze,
  // Status
  output logic first_count_gate,
  output logic second_count_gate,
  output logic [`FCS_CNT_W-1:0] display_value,
  output logic display_valid,
  output logic latch_strobe
);
  fcs_state_s r;
  fcs_state_s next_r;
  logic dec_tick [0:`FCS_DECADES];
  logic mix_pulse;
  logic tune_pulse;
  logic sub_tick;
  // ==========================================
  // Slot decode
  function automatic logic slot_hit(input logic [3:0] slot, input logic [3:0] want);
    return slot == want;
  endfunction : slot_hit
  // ==========================================
  // Decade carries
  assign dec_tick[0] = (r.pre == 20'(PRESCALE - 1));
  genvar gi;
  generate
    for (gi = 0; gi < `FCS_DECADES; gi++) begin : g_carry
      assign dec_tick[gi+1] = dec_tick[gi] && (r.dec[gi*4 +: 4] == `FCS_DECADE_LAST);
    end
  endgenerate
  // Synchronised edges; stage 0 feeds stage 1 only
  assign mix_pulse = (r.sync.mix_sync[1] == r.sync.mix_sync[2]) && r.sync.mix_sync[2]
    && !r.sync.mix_prev;
  assign tune_pulse = (r.sync.tune_sync[1] == r.sync.tune_sync[2]) && r.sync.tune_sync[2]
    && !r.sync.tune_prev;
  assign sub_tick = dec_tick[DECADES-1] && (r.slot_div == 4'(SLOT_TICKS - 1));
  // ==========================================
  // Next state
  always_comb begin
    next_r = r;
    next_r.sync.mix_sync = {r.sync.mix_sync[1:0], mixing_osc_input};
    next_r.sync.tune_sync = {r.sync.tune_sync[1:0], tuning_osc_input};
    if (r.sync.mix_sync[1] == r.sync.mix_sync[2]) begin
      next_r.sync.mix_prev = r.sync.mix_sync[2];
    end
    if (r.sync.tune_sync[1] == r.sync.tune_sync[2]) begin
      next_r.sync.tune_prev = r.sync.tune_sync[2];
    end
    next_r.pre = dec_tick[0] ? 20'h00000 : r.pre + 20'h00001;
    for (int i = 0; i < `FCS_DECADES; i++) begin
      if (dec_tick[i]) begin
        next_r.dec[i*4 +: 4] = dec_tick[i+1] ? 4'h0 : r.dec[i*4 +: 4] + 4'h1;
      end
    end
    if (dec_tick[DECADES]) begin
      next_r.gate = !r.gate;
    end
    // Slot sequencer within gate-low half
    if (dec_tick[DECADES-1]) begin
      next_r.slot_div = (r.slot_div == 4'(SLOT_TICKS - 1)) ? 4'h0 : r.slot_div + 4'h1;
    end
    if (dec_tick[DECADES] && r.gate) begin
      next_r.slot = 4'h1;
      next_r.slot_div = 4'h0;
    end else if (sub_tick && r.slot != 4'h0) begin
      next_r.slot = (r.slot == 4'(`FCS_SLOTS)) ? 4'h0 : r.slot + 4'h1;
    end
    next_r.load = 1'b0;
    next_r.latch = 1'b0;
    next_r.first_rst_n = 1'b1;
    next_r.second_rst = 1'b0;
    if (sub_tick && !r.gate) begin
      if (slot_hit(r.slot, `FCS_SLOT_LATCH)) begin
        next_r.latch = !display_freeze || (r.boot != 4'h0);
        if (r.boot != 4'h0) begin
          next_r.boot = r.boot - 4'h1;
        end
      end
      if (slot_hit(r.slot, `FCS_SLOT_LOAD)) begin
        next_r.load = 1'b1;
      end
      if (slot_hit(r.slot, `FCS_SLOT_RESET)) begin
        next_r.first_rst_n = 1'b0;
        next_r.second_rst = 1'b1;
      end
    end
    // First counter
    if (!r.first_rst_n) begin
      next_r.first_cnt = '0;
    end else if (r.gate && mix_pulse) begin
      next_r.first_cnt = r.first_cnt + `FCS_CNT_W'(1);
    end
    // Second counter
    if (r.load) begin
      next_r.second_cnt = r.first_cnt;
    end else if (r.gate && tune_pulse && beat_osc_input && display_mode) begin
      next_r.second_cnt = r.second_cnt + `FCS_CNT_W'(1);
    end
    if (r.latch) begin
      next_r.shown = r.second_cnt;
      next_r.shown_valid = 1'b1;
    end
  end
  // ==========================================
  // State register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      r <= '0;
      r.first_rst_n <= 1'b1;
      r.boot <= `FCS_POWERUP_CYCLES;
    end else begin
      r <= next_r;
    end
  end
  // ==========================================
  // Outputs
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      first_count_gate <= 1'b0;
      second_count_gate <= 1'b0;
      display_value <= '0;
      display_valid <= 1'b0;
      latch_strobe <= 1'b0;
    end else begin
      first_count_gate <= next_r.gate;
      second_count_gate <= next_r.gate && beat_osc_input && display_mode;
      display_value <= next_r.shown;
      display_valid <= next_r.shown_valid;
      latch_strobe <= next_r.latch;
    end
  end
  // ==========================================
  // Checks
  a_first_hold: assert property (@(posedge clk) disable iff (sys_rst)
    (!r.gate && r.first_rst_n)
    |=> (r.first_cnt == $past(r.first_cnt)))
    else $error("first counter moved with gate low");

  a_second_hold: assert property (@(posedge clk) disable iff (sys_rst)
    (!r.gate && !r.load)
    |=> (r.second_cnt == $past(r.second_cnt)))
    else $error("second counter moved with gate low");

  a_load_copy: assert property (@(posedge clk) disable iff (sys_rst)
    r.load
    |=> (r.second_cnt == $past(r.first_cnt)))
    else $error("load did not copy first counter");

  a_latch_copy: assert property (@(posedge clk) disable iff (sys_rst)
    r.latch
    |=> (r.shown == $past(r.second_cnt)))
    else $error("latch did not capture total");

  a_reset_clear: assert property (@(posedge clk) disable iff (sys_rst)
    !r.first_rst_n
    |=> (r.first_cnt == '0))
    else $error("reset did not clear first counter");

  a_pulse_out_gate: assert property (@(posedge clk) disable iff (sys_rst)
    (r.load || r.latch || !r.first_rst_n)
    |-> !r.gate)
    else $error("control pulse inside gate window");

  a_freeze_block: assert property (@(posedge clk) disable iff (sys_rst)
    (display_freeze && r.boot == 4'h0)
    |=> !r.latch)
    else $error("latch passed while frozen");

  a_carrier_path: assert property (@(posedge clk) disable iff (sys_rst)
    (!beat_osc_input && !r.load)
    |=> (r.second_cnt == $past(r.second_cnt)))
    else $error("second counter counted without carrier");

  a_count_step: assert property (@(posedge clk) disable iff (sys_rst)
    (r.gate && mix_pulse && r.first_rst_n)
    |=> (r.first_cnt == $past(r.first_cnt) + 1))
    else $error("first counter missed a pulse");

  a_mode_block: assert property (@(posedge clk) disable iff (sys_rst)
    (!display_mode && !r.load)
    |=> (r.second_cnt == $past(r.second_cnt)))
    else $error("second counter counted in counter mode");

  a_gate_out: assert property (@(posedge clk) disable iff (sys_rst)
    r.gate
    |-> first_count_gate)
    else $error("gate output low inside window");

  a_gate_out_low: assert property (@(posedge clk) disable iff (sys_rst)
    !r.gate
    |-> !first_count_gate)
    else $error("gate output high outside window");

  a_second_gate_out: assert property (@(posedge clk) disable iff (sys_rst)
    second_count_gate
    |-> first_count_gate)
    else $error("second gate open outside window");

  a_latch_out: assert property (@(posedge clk) disable iff (sys_rst)
    r.latch
    |-> latch_strobe)
    else $error("latch strobe missing");

  a_display_follow: assert property (@(posedge clk) disable iff (sys_rst)
    r.latch
    |=> (display_value == $past(r.second_cnt)))
    else $error("display did not take latched total");

  a_display_hold: assert property (@(posedge clk) disable iff (sys_rst)
    !r.latch
    |=> (display_value == $past(display_value)))
    else $error("display changed without latch");

  a_valid_set: assert property (@(posedge clk) disable iff (sys_rst)
    r.latch
    |=> display_valid)
    else $error("valid not set by latch");

  a_valid_sticky: assert property (@(posedge clk) disable iff (sys_rst)
    display_valid
    |=> display_valid)
    else $error("valid dropped");

  a_load_slot: assert property (@(posedge clk) disable iff (sys_rst)
    r.load
    |-> (r.slot == `FCS_SLOT_LOAD + 4'h1))
    else $error("load outside its slot");

  a_latch_slot: assert property (@(posedge clk) disable iff (sys_rst)
    r.latch
    |-> (r.slot == `FCS_SLOT_LATCH + 4'h1))
    else $error("latch outside its slot");

  a_reset_slot: assert property (@(posedge clk) disable iff (sys_rst)
    !r.first_rst_n
    |-> (r.slot == `FCS_SLOT_RESET + 4'h1))
    else $error("reset outside its slot");

  a_reset_pair: assert property (@(posedge clk) disable iff (sys_rst)
    r.second_rst
    |-> !r.first_rst_n)
    else $error("high reset without low reset");

  a_reset_both: assert property (@(posedge clk) disable iff (sys_rst)
    !r.first_rst_n
    |-> r.second_rst)
    else $error("low reset without high reset");

  a_load_single: assert property (@(posedge clk) disable iff (sys_rst)
    r.load
    |=> !r.load)
    else $error("load longer than one cycle");

  a_latch_single: assert property (@(posedge clk) disable iff (sys_rst)
    r.latch
    |=> !r.latch)
    else $error("latch longer than one cycle");

  a_rst_single: assert property (@(posedge clk) disable iff (sys_rst)
    !r.first_rst_n
    |=> r.first_rst_n)
    else $error("reset longer than one cycle");

  a_gate_steady: assert property (@(posedge clk) disable iff (sys_rst)
    !dec_tick[DECADES]
    |=> (r.gate == $past(r.gate)))
    else $error("gate toggled without carry");

  a_boot_sticky: assert property (@(posedge clk) disable iff (sys_rst)
    (r.boot == 4'h0)
    |=> (r.boot == 4'h0))
    else $error("power-up window reopened");

  a_boot_pass: assert property (@(posedge clk) disable iff (sys_rst)
    (sub_tick && !r.gate && slot_hit(r.slot, `FCS_SLOT_LATCH) && r.boot != 4'h0)
    |=> r.latch)
    else $error("latch blocked in power-up window");

  a_free_pass: assert property (@(posedge clk) disable iff (sys_rst)
    (sub_tick && !r.gate && slot_hit(r.slot, `FCS_SLOT_LATCH) && !display_freeze)
    |=> r.latch)
    else $error("latch blocked with freeze off");

  a_second_step: assert property (@(posedge clk) disable iff (sys_rst)
    (r.gate && tune_pulse && beat_osc_input && display_mode && !r.load)
    |=> (r.second_cnt == $past(r.second_cnt) + 1))
    else $error("second counter missed a pulse");

  a_slot_idle: assert property (@(posedge clk) disable iff (sys_rst)
    r.gate
    |-> (r.slot == 4'h0))
    else $error("slot sequence running in gate window");

  a_pre_wrap: assert property (@(posedge clk) disable iff (sys_rst)
    dec_tick[0]
    |=> (r.pre == 20'h00000))
    else $error("prescaler did not wrap");

  a_decade_wrap: assert property (@(posedge clk) disable iff (sys_rst)
    (dec_tick[0] && r.dec[3:0] == `FCS_DECADE_LAST)
    |=> (r.dec[3:0] == 4'h0))
    else $error("decade stage did not wrap");

endmodule : fcs_core

// *** sim/fcs_osc_model.sv ***
// Oscillator outputs feeding the frequency counter sequencer
module fcs_osc_model (
  // Half periods in 10 ns steps
  input wire logic [15:0] mix_half,
  input wire logic [15:0] tune_half,
  // Oscillator pulses
  output logic mixing_osc_input,
  output logic tuning_osc_input
);
  timeunit 1ns;
  timeprecision 100ps;
  // Free-running, offset from clk edges
  initial begin
    mixing_osc_input = 1'b0;
    #3;
    forever #(mix_half * 10) mixing_osc_input = ~mixing_osc_input;
  end
  initial begin
    tuning_osc_input = 1'b0;
    #7;
    forever #(tune_half * 10) tuning_osc_input = ~tuning_osc_input;
  end
endmodule : fcs_osc_model

// *** sim/frequency_counter_sequencer_tb.sv ***
// Self-checking bench for the frequency counter sequencer
`include "fcs_consts.svh"
module frequency_counter_sequencer_tb;
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================
  // Signals
  localparam int GATE_LEN = 100;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic carrier = 1'b1;
  logic mode = 1'b1;
  logic freeze = 1'b1;
  logic [15:0] mix_half = 16'h0005;
  logic [15:0] tune_half = 16'h0002;
  logic mix_in, tune_in, gate1, gate2, valid, latch_strobe;
  logic [`FCS_CNT_W-1:0] display_value;
  int num_errors = 0;
  int cmp_count = 0;
  int n;
  int hits;
  initial forever #5 clk = ~clk;
  fcs_osc_model osc (.mix_half(mix_half), .tune_half(tune_half),
    .mixing_osc_input(mix_in), .tuning_osc_input(tune_in));
  fcs_core #(.PRESCALE(1), .SLOT_TICKS(1), .DECADES(2)) DUT (.clk(clk), .sys_rst(sys_rst),
    .mixing_osc_input(mix_in), .tuning_osc_input(tune_in), .beat_osc_input(carrier),
    .display_mode(mode), .display_freeze(freeze), .first_count_gate(gate1),
    .second_count_gate(gate2), .display_value(display_value), .display_valid(valid),
    .latch_strobe(latch_strobe));
  // ==========================================
  // Tasks
  task automatic end_sim;
    $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_sim
  task automatic check(input string name, input int expv, input logic [23:0] got,
                       input int tol);
    cmp_count++;
    if ($isunknown(got) || got < expv - tol || got > expv + tol) begin
      num_errors++;
      $display("MISMATCH %s expected %0d seen %0d", name, expv, got);
    end
  endtask : check
  task automatic wait_lvl(ref logic sig, input logic lvl, input int lim);
    n = 0;
    while (sig !== lvl && n < lim) begin
      @(negedge clk);
      n++;
    end
    if (n >= lim) begin
      num_errors++;
      $display("MISMATCH wait expected %0d seen timeout", lvl);
      end_sim();
    end
  endtask : wait_lvl
  task automatic next_latch;
    wait_lvl(latch_strobe, 1'b0, 4);
    wait_lvl(latch_strobe, 1'b1, 250);
    repeat (2) @(negedge clk);
  endtask : next_latch
  task automatic sum_after(input string name, input int expv);
    repeat (3) next_latch();
    check(name, expv, display_value, 2);
  endtask : sum_after
  // ==========================================
  // Sequence
  initial begin
    repeat (12) @(negedge clk);
    check("valid in reset", 0, {23'h0, valid}, 0);
    sys_rst = 1'b0;
    wait_lvl(gate1, 1'b1, 300);
    repeat (4) @(negedge clk);
    check("second gate open", 1, {23'h0, gate2}, 0);
    wait_lvl(gate1, 1'b0, GATE_LEN + 10);
    check("gate length", GATE_LEN - 4, 24'(n), 1);
    sum_after("first sum", 35);
    check("valid", 1, {23'h0, valid}, 0);
    next_latch();
    tune_half = 16'h0005;
    hits = 0;
    repeat (1000) @(negedge clk) if (latch_strobe === 1'b1) hits++;
    check("blocked latches", 0, 24'(hits), 0);
    check("frozen value", 35, display_value, 2);
    freeze = 1'b0;
    sum_after("new sum", 20);
    carrier = 1'b0;
    sum_after("no carrier", 10);
    wait_lvl(gate1, 1'b1, 300);
    check("second gate no carrier", 0, {23'h0, gate2}, 0);
    carrier = 1'b1;
    mode = 1'b0;
    sum_after("counter mode", 10);
    wait_lvl(gate1, 1'b1, 300);
    check("second gate counter mode", 0, {23'h0, gate2}, 0);
    end_sim();
  end
endmodule : frequency_counter_sequencer_tb
